// file: shared/pese_params.svh
// Offsets, field positions, reset values and limits of the PHY event status block.
// Function
// - Event A bit 15 latches a link quality change seen while the link is up.
// - Event A bit 14 latches any change of energy detection status.
// - Event A bit 13 latches a pending link status change.
// - Event A bit 12 latches a pending speed change.
// - Event A bit 11 latches a pending duplex change.
// - Event A bit 10 latches autonegotiation completion.
// - Event A bit 9 latches false carrier counter passing half range.
// - Event A bit 8 latches receive error counter passing half range.
// - Event A bits 7 to 0 are writable enables for bits 15 to 8.
// - Event B bit 15 latches an energy efficient mode error.
// - Event B bit 14 latches a pending autonegotiation error.
// - Event B bit 13 latches reception of an autonegotiation page.
// - Event B bit 12 latches loopback FIFO overflow or underflow.
// - Event B bit 11 latches a crossover status change.
// - Event B bit 10 latches a pending sleep mode event.
// - Event B bit 9 latches inverted receive polarity or a received wake packet.
// - Event B bit 8 latches a pending jabber detect event.
// - Event B bits 7 to 0 are writable enables for bits 15 to 8.
// - Event interrupts reach the output only while global interrupt enable is set.
// - Polarity bit 3 set idles the output high and drives low on interrupt.
// - False carrier counter flags half-full above 7Fh and saturates at FFh.
`ifndef PESE_PARAMS_SVH
`define PESE_PARAMS_SVH

`define PESE_OFF_CTRL 5'h11
`define PESE_OFF_EVT_A 5'h12
`define PESE_OFF_EVT_B 5'h13
`define PESE_OFF_FALSE_CARRIER 5'h14
`define PESE_OFF_RX_ERROR 5'h15

`define PESE_CTRL_POL_BIT 3
`define PESE_CTRL_TEST_BIT 2
`define PESE_CTRL_GIE_BIT 1

`define PESE_EN_MSB 7
`define PESE_EN_LSB 0

`define PESE_RST_STATUS 8'h00
`define PESE_RST_ENABLE 8'h00
`define PESE_RST_GIE 1'b0
`define PESE_RST_TEST 1'b0
`define PESE_RST_POL 1'b1
`define PESE_RST_RDDATA 16'h0000
`define PESE_RST_COUNT 8'h00

`define PESE_CNT_MAX 8'hFF
`define PESE_CNT_HALF 8'h7F

`endif

// file: shared/pese_pkg.sv
// Types shared by the PHY event status block.
package pese_pkg;

   typedef enum logic [5:0] {
      PESE_SEL_NONE = 6'h01,
      PESE_SEL_CTRL = 6'h02,
      PESE_SEL_EVT_A = 6'h04,
      PESE_SEL_EVT_B = 6'h08,
      PESE_SEL_FC = 6'h10,
      PESE_SEL_RE = 6'h20
   } pese_sel_e;

   typedef struct packed {
      logic [7:0] statusA;
      logic [7:0] enableA;
      logic [7:0] statusB;
      logic [7:0] enableB;
      logic globalEn;
      logic testInt;
      logic polarity;
      logic [15:0] rdData;
      logic intOut;
   } pese_state_s;

   typedef struct packed {
      logic [7:0] count;
      logic halfEvt;
   } pese_cnt_s;

endpackage : pese_pkg

// file: core/pese_event_counter.sv
// Saturating event counter, cleared on read, with a half-range event pulse.
`include "pese_params.svh"

module pese_event_counter (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic incr,
   input wire logic clearOnRead,
   output logic [7:0] count,
   output logic halfEvt
);

   pese_pkg::pese_cnt_s cnt_q;
   pese_pkg::pese_cnt_s cnt_d;
   logic [7:0] base;

   always_comb begin
      cnt_d = cnt_q;
      base = clearOnRead ? `PESE_RST_COUNT : cnt_q.count;
      cnt_d.halfEvt = 1'b0;
      // An event in the clearing cycle is counted into the fresh value.
      if (incr && base != `PESE_CNT_MAX) begin
         cnt_d.count = base + 8'h01;
         cnt_d.halfEvt = (base == `PESE_CNT_HALF);
      end else begin
         cnt_d.count = base;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '{count: `PESE_RST_COUNT, halfEvt: 1'b0};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign count = cnt_q.count;
   assign halfEvt = cnt_q.halfEvt;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_count_saturates: assert property ((count == 8'hFF && !clearOnRead) |=> count == 8'hFF)
      else $error("Counter left its saturated value.");
   a_half_crossing: assert property (halfEvt |-> ($past(count) == 8'h7F && count == 8'h80))
      else $error("Half-full event without crossing 7Fh.");

endmodule : pese_event_counter

// file: core/pese_event_status.sv
// Event status and enable registers with the combined interrupt output.
`include "pese_params.svh"

module pese_event_status (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   input wire logic linkUp,
   input wire logic linkQualityChange,
   input wire logic energyDetectChange,
   input wire logic linkStatusChange,
   input wire logic speedChange,
   input wire logic duplexChange,
   input wire logic autonegComplete,
   input wire logic falseCarrierEvent,
   input wire logic receiveErrorEvent,
   input wire logic energyEfficientModeError,
   input wire logic autonegError,
   input wire logic pageReceived,
   input wire logic loopbackFifoFault,
   input wire logic crossoverChange,
   input wire logic sleepEvent,
   input wire logic polarityInverted,
   input wire logic wakePacketReceived,
   input wire logic jabberDetect,
   output logic intOut
);

   ////////////////////////////////////////////////////////////////////////////////
   localparam pese_pkg::pese_state_s STATE_RST = '{
      statusA: `PESE_RST_STATUS,
      enableA: `PESE_RST_ENABLE,
      statusB: `PESE_RST_STATUS,
      enableB: `PESE_RST_ENABLE,
      globalEn: `PESE_RST_GIE,
      testInt: `PESE_RST_TEST,
      polarity: `PESE_RST_POL,
      rdData: `PESE_RST_RDDATA,
      intOut: `PESE_RST_POL
   };

   pese_pkg::pese_state_s st_q;
   pese_pkg::pese_state_s st_d;
   pese_pkg::pese_sel_e sel;
   logic [7:0] evtA;
   logic [7:0] evtB;
   logic [7:0] fcCount;
   logic [7:0] reCount;
   logic fcHalf;
   logic reHalf;
   logic rdA;
   logic rdB;
   logic rdFc;
   logic rdRe;
   logic wrA;
   logic wrB;
   logic wrCtrl;
   logic pending;
   logic [15:0] ctrlRd;

   ////////////////////////////////////////////////////////////////////////////////
   // Both counters share one module; the receive error counter is kept 8 bits wide.
   pese_event_counter uFalseCarrier (
      .ref_clk(ref_clk),
      .rst(rst),
      .incr(falseCarrierEvent),
      .clearOnRead(rdFc),
      .count(fcCount),
      .halfEvt(fcHalf)
   );

   pese_event_counter uRxError (
      .ref_clk(ref_clk),
      .rst(rst),
      .incr(receiveErrorEvent),
      .clearOnRead(rdRe),
      .count(reCount),
      .halfEvt(reHalf)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      if (regAddr == `PESE_OFF_CTRL) begin
         sel = pese_pkg::PESE_SEL_CTRL;
      end else if (regAddr == `PESE_OFF_EVT_A) begin
         sel = pese_pkg::PESE_SEL_EVT_A;
      end else if (regAddr == `PESE_OFF_EVT_B) begin
         sel = pese_pkg::PESE_SEL_EVT_B;
      end else if (regAddr == `PESE_OFF_FALSE_CARRIER) begin
         sel = pese_pkg::PESE_SEL_FC;
      end else if (regAddr == `PESE_OFF_RX_ERROR) begin
         sel = pese_pkg::PESE_SEL_RE;
      end else begin
         sel = pese_pkg::PESE_SEL_NONE;
      end
   end

   assign rdA = regRdEn && sel == pese_pkg::PESE_SEL_EVT_A;
   assign rdB = regRdEn && sel == pese_pkg::PESE_SEL_EVT_B;
   assign rdFc = regRdEn && sel == pese_pkg::PESE_SEL_FC;
   assign rdRe = regRdEn && sel == pese_pkg::PESE_SEL_RE;
   assign wrA = regWrEn && sel == pese_pkg::PESE_SEL_EVT_A;
   assign wrB = regWrEn && sel == pese_pkg::PESE_SEL_EVT_B;
   assign wrCtrl = regWrEn && sel == pese_pkg::PESE_SEL_CTRL;

   ////////////////////////////////////////////////////////////////////////////////
   // Event sources, ordered from status bit 15 down to bit 8.
   always_comb begin
      evtA[7] = linkQualityChange & linkUp;
      evtA[6] = energyDetectChange;
      evtA[5] = linkStatusChange;
      evtA[4] = speedChange;
      evtA[3] = duplexChange;
      evtA[2] = autonegComplete;
      evtA[1] = fcHalf;
      evtA[0] = reHalf;
      evtB[7] = energyEfficientModeError;
      evtB[6] = autonegError;
      evtB[5] = pageReceived;
      evtB[4] = loopbackFifoFault;
      evtB[3] = crossoverChange;
      evtB[2] = sleepEvent;
      evtB[1] = polarityInverted | wakePacketReceived;
      evtB[0] = jabberDetect;
   end

   always_comb begin
      ctrlRd = 16'h0000;
      ctrlRd[`PESE_CTRL_POL_BIT] = st_q.polarity;
      ctrlRd[`PESE_CTRL_TEST_BIT] = st_q.testInt;
      ctrlRd[`PESE_CTRL_GIE_BIT] = st_q.globalEn;
   end

   // The test bit bypasses the global enable so the pin can be checked alone.
   always_comb begin
      pending = st_q.testInt;
      if (st_q.globalEn) begin
         pending = pending | (|(st_q.statusA & st_q.enableA)) | (|(st_q.statusB & st_q.enableB));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      // A read clears first, then new events set, so a colliding event survives.
      if (rdA) begin
         st_d.statusA = `PESE_RST_STATUS;
      end
      if (rdB) begin
         st_d.statusB = `PESE_RST_STATUS;
      end
      st_d.statusA = st_d.statusA | evtA;
      st_d.statusB = st_d.statusB | evtB;
      if (wrA) begin
         st_d.enableA = regWrData[`PESE_EN_MSB:`PESE_EN_LSB];
      end
      if (wrB) begin
         st_d.enableB = regWrData[`PESE_EN_MSB:`PESE_EN_LSB];
      end
      if (wrCtrl) begin
         st_d.polarity = regWrData[`PESE_CTRL_POL_BIT];
         st_d.testInt = regWrData[`PESE_CTRL_TEST_BIT];
         st_d.globalEn = regWrData[`PESE_CTRL_GIE_BIT];
      end
      if (regRdEn) begin
         unique case (sel)
            pese_pkg::PESE_SEL_CTRL: begin
               st_d.rdData = ctrlRd;
            end
            pese_pkg::PESE_SEL_EVT_A: begin
               st_d.rdData = {st_q.statusA, st_q.enableA};
            end
            pese_pkg::PESE_SEL_EVT_B: begin
               st_d.rdData = {st_q.statusB, st_q.enableB};
            end
            pese_pkg::PESE_SEL_FC: begin
               st_d.rdData = {8'h00, fcCount};
            end
            pese_pkg::PESE_SEL_RE: begin
               st_d.rdData = {8'h00, reCount};
            end
            pese_pkg::PESE_SEL_NONE: begin
               st_d.rdData = 16'h0000;
            end
         endcase
      end
      st_d.intOut = st_q.polarity ? ~pending : pending;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q <= STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData = st_q.rdData;
   assign intOut = st_q.intOut;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks tie outputs and latched state to their causes one edge later; the enable A write check looks two edges later.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_link_quality_gate: assert property ((linkQualityChange && !linkUp && !rdA) |=>
         st_q.statusA[7] == $past(st_q.statusA[7]))
      else $error("Link quality bit moved while the link was down.");

   a_events_a_latch: assert property ((evtA != 8'h00) |=>
         ((st_q.statusA & $past(evtA)) == $past(evtA)))
      else $error("Event A was lost.");

   a_events_b_latch: assert property ((evtB != 8'h00) |=>
         ((st_q.statusB & $past(evtB)) == $past(evtB)))
      else $error("Event B was lost.");

   a_shared_flag: assert property ((wakePacketReceived || polarityInverted) |=> st_q.statusB[1])
      else $error("Polarity or wake event did not set bit 9.");

   a_read_clears_a: assert property ((rdA && evtA == 8'h00) |=>
         (st_q.statusA == 8'h00 && regRdData[15:8] == $past(st_q.statusA)))
      else $error("Read of event A did not return and clear status.");

   a_read_clears_b: assert property ((rdB && evtB == 8'h00) |=>
         (st_q.statusB == 8'h00 && regRdData[15:8] == $past(st_q.statusB)))
      else $error("Read of event B did not return and clear status.");

   a_status_holds: assert property ((!rdA && evtA == 8'h00) |=> st_q.statusA == $past(st_q.statusA))
      else $error("Status A changed without event or read.");

   a_enable_write: assert property (wrA ##1 (!wrA)[*2] |->
         st_q.enableA == $past(regWrData[7:0], 2))
      else $error("Enable A write was not kept.");

   a_enable_write_b: assert property (wrB |=> st_q.enableB == $past(regWrData[7:0]))
      else $error("Enable B write was not taken.");

   a_global_gate: assert property ((!st_q.globalEn && !st_q.testInt) |=>
         intOut == $past(st_q.polarity))
      else $error("Interrupt asserted with global enable clear.");

   a_active_level: assert property ((st_q.globalEn && (|(st_q.statusA & st_q.enableA))) |=>
         intOut == !$past(st_q.polarity))
      else $error("Enabled pending event did not drive the active level.");

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, enables and the pin level are each tied to the cycle that caused them.
   a_rd_a_data: assert property (rdA |=>
         regRdData == {$past(st_q.statusA), $past(st_q.enableA)})
      else $error("Read of event A returned the wrong word.");

   a_rd_b_data: assert property (rdB |=>
         regRdData == {$past(st_q.statusB), $past(st_q.enableB)})
      else $error("Read of event B returned the wrong word.");

   a_collide_keeps_a: assert property (rdA |=>
         st_q.statusA == $past(evtA))
      else $error("Event arriving with the read of A was lost.");

   a_collide_keeps_b: assert property (rdB |=>
         st_q.statusB == $past(evtB))
      else $error("Event arriving with the read of B was lost.");

   a_status_b_holds: assert property ((!rdB && evtB == 8'h00) |=>
         st_q.statusB == $past(st_q.statusB))
      else $error("Status B changed without event or read.");

   a_enable_a_holds: assert property (!wrA |=>
         $stable(st_q.enableA))
      else $error("Enable A changed without a write.");

   a_enable_b_holds: assert property (!wrB |=>
         $stable(st_q.enableB))
      else $error("Enable B changed without a write.");

   a_lq_link_up: assert property ((linkQualityChange && linkUp) |=>
         st_q.statusA[7])
      else $error("Link quality change with link up was not latched.");

   a_energy_detect: assert property (energyDetectChange |=>
         st_q.statusA[6])
      else $error("Energy detect change was not latched.");

   a_link_status: assert property (linkStatusChange |=>
         st_q.statusA[5])
      else $error("Link status change was not latched.");

   a_fc_half_sets: assert property (fcHalf |=>
         st_q.statusA[1])
      else $error("False carrier half event did not set bit 9.");

   a_re_half_sets: assert property (reHalf |=>
         st_q.statusA[0])
      else $error("Receive error half event did not set bit 8.");

   a_jabber_sets: assert property (jabberDetect |=>
         st_q.statusB[0])
      else $error("Jabber event did not set bit 8.");

   a_ctrl_write: assert property (wrCtrl |=>
         {st_q.polarity, st_q.testInt, st_q.globalEn} == $past(regWrData[`PESE_CTRL_POL_BIT:`PESE_CTRL_GIE_BIT]))
      else $error("Control write was not taken.");

   a_ctrl_read: assert property ((regRdEn && sel == pese_pkg::PESE_SEL_CTRL) |=>
         regRdData == {12'h000, $past(st_q.polarity), $past(st_q.testInt), $past(st_q.globalEn), 1'b0})
      else $error("Control read returned the wrong word.");

   a_unmapped_read: assert property ((regRdEn && sel == pese_pkg::PESE_SEL_NONE) |=>
         regRdData == 16'h0000)
      else $error("Unmapped read returned a nonzero word.");

   a_fc_read: assert property (rdFc |=>
         regRdData == {8'h00, $past(fcCount)})
      else $error("False carrier count read returned the wrong word.");

   a_re_read: assert property (rdRe |=>
         regRdData == {8'h00, $past(reCount)})
      else $error("Receive error count read returned the wrong word.");

   a_rddata_holds: assert property (!regRdEn |=>
         $stable(regRdData))
      else $error("Read data changed without a read.");

   a_test_forces: assert property (st_q.testInt |=>
         intOut == !$past(st_q.polarity))
      else $error("Test bit did not drive the active level.");

   a_idle_level: assert property ((!st_q.testInt && (st_q.statusA & st_q.enableA) == 8'h00 &&
         (st_q.statusB & st_q.enableB) == 8'h00) |=> intOut == $past(st_q.polarity))
      else $error("Interrupt active with nothing enabled pending.");

   a_active_level_b: assert property ((st_q.globalEn && (|(st_q.statusB & st_q.enableB))) |=>
         intOut == !$past(st_q.polarity))
      else $error("Enabled pending event B did not drive the active level.");

   c_event_to_irq: cover property (st_q.globalEn && linkStatusChange && st_q.enableA[5] ##2 intOut == 1'b0);
   c_test_int: cover property (st_q.testInt && !st_q.globalEn);
   c_read_collision: cover property (rdA && evtA != 8'h00);
   c_counter_half: cover property (fcHalf);
   c_wake_packet: cover property (wakePacketReceived && st_q.enableB[1]);

endmodule : pese_event_status

// file: dv/pese_host_model.sv
// Station management host model that drives the register port of the event block.
module pese_host_model (
   input wire logic ref_clk,
   input wire logic [15:0] regRdData,
   output logic [4:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWrEn,
   output logic regRdEn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      regAddr = 5'h00;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge ref_clk);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge ref_clk);
      regWrEn = 1'b0;
      // Released lines show the inverse, so a stale value can never pass for a live one.
      regAddr = ~a;
      regWrData = ~v;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge ref_clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData;
   endtask : rd
endmodule : pese_host_model

// file: dv/phy_event_status_enable_tb_top.sv
// Self-checking bench for the event status and enable registers.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module phy_event_status_enable_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic linkUp = 1'b1;
   logic [16:0] ev = '0;
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, d, e;
   logic regWrEn, regRdEn, intOut;
   logic [4:0] a;
   int num_errors = 0;
   int n_checks = 0;
   pese_host_model host (.ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn));
   pese_event_status uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .linkUp(linkUp),
      .linkQualityChange(ev[0]), .energyDetectChange(ev[1]), .linkStatusChange(ev[2]), .speedChange(ev[3]),
      .duplexChange(ev[4]), .autonegComplete(ev[5]), .energyEfficientModeError(ev[6]), .autonegError(ev[7]),
      .pageReceived(ev[8]), .loopbackFifoFault(ev[9]), .crossoverChange(ev[10]), .sleepEvent(ev[11]),
      .polarityInverted(ev[12]), .wakePacketReceived(ev[13]), .jabberDetect(ev[14]),
      .falseCarrierEvent(ev[15]), .receiveErrorEvent(ev[16]), .intOut(intOut));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         @(negedge ref_clk);
         ev[i] = 1'b1;
         @(negedge ref_clk);
         ev[i] = 1'b0;
      end
   endtask : pulse
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      `CHK("intOut", 1'b1, intOut)
      host.rd(5'h11, d);
      `CHK("ctrl", 16'h0008, d)
      host.rd(5'h1F, d);
      `CHK("unmapped", 16'h0000, d)
      host.wr(5'h12, 16'hFFFF);
      host.rd(5'h12, d);
      `CHK("evtA", 16'h00FF, d)
      host.wr(5'h13, 16'hFFFF);
      host.rd(5'h13, d);
      `CHK("evtB", 16'h00FF, d)
      // Each event lands on its own status bit; the polarity and wake inputs share one.
      for (int i = 0; i < 15; i++) begin
         pulse(i, 1);
         a = (i < 6) ? 5'h12 : 5'h13;
         e = 16'h8000 >> ((i < 6) ? i : (i < 12) ? i - 6 : (i < 14) ? 6 : 7);
         host.rd(a, d);
         `CHK("status", e | 16'h00FF, d)
         host.rd(a, d);
         `CHK("cleared", 16'h00FF, d)
      end
      linkUp = 1'b0;
      pulse(0, 1);
      host.rd(5'h12, d);
      `CHK("lqDown", 16'h00FF, d)
      linkUp = 1'b1;
      pulse(2, 1);
      @(negedge ref_clk);
      `CHK("noGie", 1'b1, intOut)
      host.wr(5'h11, 16'h000A);
      @(negedge ref_clk);
      `CHK("intLow", 1'b0, intOut)
      host.wr(5'h11, 16'h0002);
      @(negedge ref_clk);
      `CHK("intHigh", 1'b1, intOut)
      host.rd(5'h12, d);
      `CHK("handler", 16'h20FF, d)
      @(negedge ref_clk);
      `CHK("intIdle", 1'b0, intOut)
      host.wr(5'h12, 16'h00DF);
      pulse(2, 1);
      @(negedge ref_clk);
      `CHK("masked", 1'b0, intOut)
      host.rd(5'h12, d);
      `CHK("maskedSt", 16'h20DF, d)
      pulse(15, 127);
      host.rd(5'h12, d);
      `CHK("fc127", 16'h00DF, d)
      pulse(15, 1);
      host.rd(5'h12, d);
      `CHK("fcHalf", 16'h02DF, d)
      host.wr(5'h14, 16'h5555);
      host.rd(5'h14, d);
      `CHK("fcCount", 16'h0080, d)
      pulse(16, 128);
      host.rd(5'h12, d);
      `CHK("reHalf", 16'h01DF, d)
      host.rd(5'h15, d);
      `CHK("reCount", 16'h0080, d)
      pulse(15, 300);
      host.rd(5'h14, d);
      `CHK("fcSat", 16'h00FF, d)
      host.wr(5'h11, 16'h000C);
      @(negedge ref_clk);
      `CHK("testInt", 1'b0, intOut)
      host.rd(5'h11, d);
      `CHK("ctrlTest", 16'h000C, d)
      host.wr(5'h11, 16'h0008);
      @(negedge ref_clk);
      `CHK("gieOff", 1'b1, intOut)
      close_out();
   end
endmodule : phy_event_status_enable_tb_top
